// >>> core/sleep_wake_pkg.sv
// constants for the sleep/wake supervisor: register map, fields, reset values, timing
// assumes a 250 MHz system clock and a single register port with one-cycle read latency
// Functional notes
// - leave running for quiescent on software or USB sleep request.
// - wake stimuli act only in the quiescent state.
// - wake stimulus seen while going to sleep is held and acted on at arrival.
// - wake on pin edge of chosen polarity, counter alarm, or USB resume if enabled.
// - counter adds one per main clock tick while running.
// - counter may switch to the slow oscillator while quiescent.
// - each slow tick adds a programmable increment to the counter.
// - supply loss during either transition issues a system reset.
// - hold chip in reset at power-up until all supplies good.
// - supply drop holds reset until restored, then cold start.
// - watchdog is 16-bit, 1 ms resolution, timeout 1 ms to about 65 s.
// - watchdog not refreshed before expiry resets the chip.
// - readable flag tells whether last reset came from the watchdog.
// - watchdog counts only while running, independent of the counter.
// - 128 bytes of memory retained through the quiescent state.
package sleep_wake_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam int          RETAIN_BYTES    = 128;
	localparam int          RETAIN_WORDS    = RETAIN_BYTES / 4;
	localparam int          CLK_HZ          = 250_000_000;
	localparam int          WDOG_TICK_MS    = 1;
	localparam int          WDOG_TICK_CYC   = CLK_HZ / 1000 * WDOG_TICK_MS;
	localparam int          STEP_CYC        = 4;

	localparam logic [7:0]  OFS_CTRL        = 8'h00;
	localparam logic [7:0]  OFS_STATUS      = 8'h04;
	localparam logic [7:0]  OFS_WAKE_CFG    = 8'h08;
	localparam logic [7:0]  OFS_ALARM_LO    = 8'h0c;
	localparam logic [7:0]  OFS_ALARM_HI    = 8'h10;
	localparam logic [7:0]  OFS_INCR        = 8'h14;
	localparam logic [7:0]  OFS_RTC_LO      = 8'h18;
	localparam logic [7:0]  OFS_RTC_HI      = 8'h1c;
	localparam logic [7:0]  OFS_WDOG        = 8'h20;
	localparam logic [7:0]  OFS_IRQ_STAT    = 8'h24;
	localparam logic [7:0]  OFS_IRQ_MASK    = 8'h28;
	localparam logic [7:0]  OFS_SLEEP_CFG   = 8'h2c;
	localparam logic [7:0]  OFS_RETAIN      = 8'h80;

	// ctrl bits
	localparam int          CTRL_SLEEP      = 0;
	localparam int          CTRL_WD_KICK    = 1;
	// wake cfg bits
	localparam int          WK_PIN_EN       = 0;
	localparam int          WK_PIN_POL      = 1;
	localparam int          WK_ALARM_EN     = 2;
	localparam int          WK_USB_EN       = 3;
	localparam int          WK_SLOW_OSC     = 4;
	// interrupt status bits
	localparam int          IRQ_WAKE        = 0;
	localparam int          IRQ_SLEEP       = 1;
	localparam int          IRQ_ALARM       = 2;
	localparam int          IRQ_W           = 3;

	localparam logic [31:0] INCR_RST        = 32'h0000_0001;
	localparam logic [15:0] WDOG_RST        = 16'h0000;
	localparam logic [5:0]  SLEEP_CFG_RST   = 6'h00;

	typedef enum logic [2:0] {
		ST_POWER_UP,
		ST_AWAKE,
		ST_GO_SLEEP1,
		ST_GO_SLEEP2,
		ST_ASLEEP,
		ST_GO_WAKE1,
		ST_GO_WAKE2
	} pwr_state_t;
endpackage

// >>> core/sleep_wake_supervisor.sv
// power-mode controller, real-time counter, watchdog and retained memory
// assumes pins, supply flags and the slow tick arrive asynchronously; usb requests are on clk
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module sleep_wake_supervisor (
	input  wire logic                           clk,
	input  wire logic                           rst_b,
	input  wire logic [sleep_wake_pkg::ADDR_W-1:0] addr,
	input  wire logic [sleep_wake_pkg::DATA_W-1:0] wdata,
	input  wire logic                           wr,
	input  wire logic                           rd,
	output logic      [sleep_wake_pkg::DATA_W-1:0] rdata,
	input  wire logic                           usb_standby_req,
	input  wire logic                           usb_resume,
	input  wire logic                           wake_pin,
	input  wire logic                           slow_osc,
	input  wire logic [2:0]                     supply_good,
	output logic                                chip_reset_b,
	output logic                                awake,
	output logic [5:0]                          sleep_ctrl,
	output logic                                irq
);
	import sleep_wake_pkg::*;

	logic [4:0]        async_s;
	logic              pin_s;
	logic              slow_s;
	logic              slow_d_r;
	logic              pin_d_r;
	logic              all_good;
	pwr_state_t        st_r;
	pwr_state_t        st_nxt;
	logic [2:0]        step_r;
	logic [4:0]        wake_cfg_r;
	logic [4:0]        wake_cfg_live_r;
	logic [63:0]       alarm_r;
	logic [63:0]       alarm_live_r;
	logic [31:0]       incr_r;
	logic [31:0]       incr_live_r;
	logic [63:0]       rtc_r;
	logic [15:0]       wd_load_r;
	logic [15:0]       wd_cnt_r;
	logic [17:0]       wd_pre_r;
	logic              wd_fire;
	logic              wd_cause_r;
	logic              wake_pend_r;
	logic              wake_stim;
	logic              sleep_req;
	logic              trans_fault;
	logic [IRQ_W-1:0]  irq_stat_r;
	logic [IRQ_W-1:0]  irq_mask_r;
	logic [IRQ_W-1:0]  irq_set;
	logic [31:0]       retain_r [RETAIN_WORDS];
	logic              in_trans;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	sync2 #(.W(5)) u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.d     ({wake_pin, slow_osc, supply_good}),
		.q     (async_s)
	);
	assign pin_s    = async_s[4];
	assign slow_s   = async_s[3];
	assign all_good = &async_s[2:0];
	assign in_trans = (st_r == ST_GO_SLEEP1) || (st_r == ST_GO_SLEEP2) ||
	                  (st_r == ST_GO_WAKE1) || (st_r == ST_GO_WAKE2);

	// requests are honoured only in awake; elsewhere they are dropped
	assign sleep_req = (wr && hit(addr, OFS_CTRL) && wdata[CTRL_SLEEP]) || usb_standby_req;

	// pin edge in programmed direction, counter at or past alarm, usb resume
	assign wake_stim = (wake_cfg_live_r[WK_PIN_EN] &&
	                    (wake_cfg_live_r[WK_PIN_POL] ? (pin_s && !pin_d_r) : (!pin_s && pin_d_r))) ||
	                   (wake_cfg_live_r[WK_ALARM_EN] && (rtc_r >= alarm_live_r)) ||
	                   (wake_cfg_live_r[WK_USB_EN] && usb_resume);

	assign trans_fault = in_trans && !all_good;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pin_d_r  <= 1'b0;
			slow_d_r <= 1'b0;
		end
		else
		begin
			pin_d_r  <= pin_s;
			slow_d_r <= slow_s;
		end
	end

	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			ST_POWER_UP:  if (all_good) st_nxt = ST_AWAKE;
			ST_AWAKE:     if (sleep_req) st_nxt = ST_GO_SLEEP1;
			ST_GO_SLEEP1: if (step_r == 3'(STEP_CYC - 1)) st_nxt = ST_GO_SLEEP2;
			ST_GO_SLEEP2: if (step_r == 3'(STEP_CYC - 1)) st_nxt = ST_ASLEEP;
			ST_ASLEEP:    if (wake_pend_r || wake_stim) st_nxt = ST_GO_WAKE1;
			ST_GO_WAKE1:  if (step_r == 3'(STEP_CYC - 1)) st_nxt = ST_GO_WAKE2;
			ST_GO_WAKE2:  if (step_r == 3'(STEP_CYC - 1)) st_nxt = ST_AWAKE;
			default:      st_nxt = ST_POWER_UP;
		endcase
		// any supply loss, fault in transition or watchdog forces a cold start
		if (!all_good || trans_fault || wd_fire)
			st_nxt = ST_POWER_UP;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_r   <= ST_POWER_UP;
			step_r <= 3'h0;
		end
		else
		begin
			st_r   <= st_nxt;
			step_r <= (st_nxt != st_r) ? 3'h0 : step_r + 3'h1;
		end
	end

	// held stimulus during the sleep descent, consumed on arrival
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			wake_pend_r <= 1'b0;
		else if (st_r == ST_GO_SLEEP1 || st_r == ST_GO_SLEEP2)
			wake_pend_r <= wake_pend_r | wake_stim;
		else
			wake_pend_r <= 1'b0;
	end

	// shadow copies load on every awake cycle and hold outside awake, so writes made outside awake wait for the next awake
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wake_cfg_live_r <= 5'h00;
			alarm_live_r    <= 64'hffff_ffff_ffff_ffff;
			incr_live_r     <= INCR_RST;
		end
		else if (st_r == ST_AWAKE)
		begin
			wake_cfg_live_r <= wake_cfg_r;
			alarm_live_r    <= alarm_r;
			incr_live_r     <= incr_r;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rtc_r <= 64'h0;
		else if (st_r == ST_ASLEEP && wake_cfg_live_r[WK_SLOW_OSC])
		begin
			if (slow_s && !slow_d_r)
				rtc_r <= rtc_r + {32'h0, incr_live_r};
		end
		else
			rtc_r <= rtc_r + 64'h1;
	end

	// watchdog: zero load disables; prescaler gives 1 ms ticks
	assign wd_fire = (st_r == ST_AWAKE) && (wd_load_r != 16'h0) && (wd_cnt_r == 16'h0) &&
	                 (wd_pre_r == 18'(WDOG_TICK_CYC - 1));

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wd_cnt_r <= WDOG_RST;
			wd_pre_r <= 18'h0;
		end
		else if (st_r != ST_AWAKE || (wr && hit(addr, OFS_CTRL) && wdata[CTRL_WD_KICK]) ||
		         (wr && hit(addr, OFS_WDOG)))
		begin
			wd_cnt_r <= (wr && hit(addr, OFS_WDOG)) ? wdata[15:0] - 16'h1 : wd_load_r - 16'h1;
			wd_pre_r <= 18'h0;
		end
		else if (wd_pre_r == 18'(WDOG_TICK_CYC - 1))
		begin
			wd_pre_r <= 18'h0;
			wd_cnt_r <= wd_cnt_r - 16'h1;
		end
		else
			wd_pre_r <= wd_pre_r + 18'h1;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			wd_cause_r <= 1'b0;
		else if (wd_fire)
			wd_cause_r <= 1'b1;
		else if (st_r == ST_POWER_UP && !all_good)
			wd_cause_r <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wake_cfg_r <= 5'h00;
			alarm_r    <= 64'hffff_ffff_ffff_ffff;
			incr_r     <= INCR_RST;
			wd_load_r  <= WDOG_RST;
			irq_mask_r <= '0;
			sleep_ctrl <= SLEEP_CFG_RST;
		end
		else if (wr)
		begin
			if (hit(addr, OFS_WAKE_CFG))  wake_cfg_r     <= wdata[4:0];
			if (hit(addr, OFS_ALARM_LO))  alarm_r[31:0]  <= wdata;
			if (hit(addr, OFS_ALARM_HI))  alarm_r[63:32] <= wdata;
			if (hit(addr, OFS_INCR))      incr_r         <= wdata;
			if (hit(addr, OFS_WDOG))      wd_load_r      <= wdata[15:0];
			if (hit(addr, OFS_IRQ_MASK))  irq_mask_r     <= wdata[IRQ_W-1:0];
			if (hit(addr, OFS_SLEEP_CFG)) sleep_ctrl     <= wdata[5:0];
		end
	end

	// retained words survive asleep; not even the async reset clears them
	always_ff @(posedge clk)
	begin
		if (wr && addr[7] && (st_r == ST_AWAKE))
			retain_r[addr[6:2]] <= wdata;
	end

	assign irq_set[IRQ_WAKE]  = (st_r == ST_GO_WAKE2) && (st_nxt == ST_AWAKE);
	assign irq_set[IRQ_SLEEP] = (st_r == ST_GO_SLEEP2) && (st_nxt == ST_ASLEEP);
	assign irq_set[IRQ_ALARM] = (rtc_r == alarm_live_r);

	// set wins over the read clear
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			irq_stat_r <= '0;
		else if (rd && hit(addr, OFS_IRQ_STAT))
			irq_stat_r <= irq_set;
		else
			irq_stat_r <= irq_stat_r | irq_set;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			irq <= 1'b0;
		else
			irq <= |(((rd && hit(addr, OFS_IRQ_STAT)) ? irq_set : (irq_stat_r | irq_set)) & irq_mask_r);
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			chip_reset_b <= 1'b0;
			awake        <= 1'b0;
		end
		else
		begin
			chip_reset_b <= (st_nxt != ST_POWER_UP);
			awake        <= (st_nxt == ST_AWAKE);
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rdata <= '0;
		else if (rd)
		begin
			rdata <= '0;
			if (addr[7])                  rdata <= retain_r[addr[6:2]];
			if (hit(addr, OFS_STATUS))    rdata <= {27'h0, wd_cause_r, wake_pend_r, st_r};
			if (hit(addr, OFS_WAKE_CFG))  rdata <= {27'h0, wake_cfg_r};
			if (hit(addr, OFS_ALARM_LO))  rdata <= alarm_r[31:0];
			if (hit(addr, OFS_ALARM_HI))  rdata <= alarm_r[63:32];
			if (hit(addr, OFS_INCR))      rdata <= incr_r;
			if (hit(addr, OFS_RTC_LO))    rdata <= rtc_r[31:0];
			if (hit(addr, OFS_RTC_HI))    rdata <= rtc_r[63:32];
			if (hit(addr, OFS_WDOG))      rdata <= {16'h0, wd_load_r};
			if (hit(addr, OFS_IRQ_STAT))  rdata <= {29'h0, irq_stat_r};
			if (hit(addr, OFS_IRQ_MASK))  rdata <= {29'h0, irq_mask_r};
			if (hit(addr, OFS_SLEEP_CFG)) rdata <= {26'h0, sleep_ctrl};
		end
		else
			rdata <= '0;
	end

	sleep_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r == ST_AWAKE && sleep_req && all_good && !wd_fire) |=> st_r == ST_GO_SLEEP1)
		else $error("sleep request not taken");
	wake_only_asleep_a: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r == ST_AWAKE) |=> (st_r != ST_GO_WAKE1))
		else $error("wake left from a non-sleep state");
	held_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r == ST_ASLEEP && wake_pend_r && all_good) |=> st_r == ST_GO_WAKE1)
		else $error("held wake stimulus lost");
	rtc_awake_a: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r == ST_AWAKE) |=> rtc_r == $past(rtc_r) + 64'h1)
		else $error("counter did not tick");
	// supplies may come back at once, so only the first cycle is checked
	trans_fault_a: assert property (@(posedge clk) disable iff (!rst_b)
		trans_fault |=> (st_r == ST_POWER_UP && !chip_reset_b))
		else $error("transition fault without reset");
	powerup_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!all_good) |=> !chip_reset_b)
		else $error("reset released with bad supply");
	supply_loss_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!all_good) |=> st_r == ST_POWER_UP)
		else $error("supply loss did not force power up");
	transition_len_a: assert property (@(posedge clk) disable iff (!rst_b)
		($rose(st_r == ST_GO_SLEEP1) && all_good) |=> (st_r == ST_GO_SLEEP1 || st_r == ST_POWER_UP) [*3])
		else $error("transition stage too short");
	sleep_path_a: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r == ST_GO_SLEEP2 && all_good) |=> (st_r == ST_GO_SLEEP2 || st_r == ST_ASLEEP))
		else $error("descent left its fixed order");
	wake_path_a: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r == ST_GO_WAKE1 && all_good) |=> (st_r == ST_GO_WAKE1 || st_r == ST_GO_WAKE2))
		else $error("ascent left its fixed order");
	usb_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r == ST_ASLEEP && wake_cfg_live_r[WK_USB_EN] && usb_resume && all_good) |=> st_r == ST_GO_WAKE1)
		else $error("usb resume did not wake");
	slow_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r == ST_ASLEEP && wake_cfg_live_r[WK_SLOW_OSC] && !(slow_s && !slow_d_r)) |=> $stable(rtc_r))
		else $error("counter moved between slow ticks");
	slow_step_a: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r == ST_ASLEEP && wake_cfg_live_r[WK_SLOW_OSC] && slow_s && !slow_d_r) |=>
		rtc_r == $past(rtc_r) + {32'h0, $past(incr_live_r)})
		else $error("slow tick added wrong increment");
	wd_reset_a: assert property (@(posedge clk) disable iff (!rst_b)
		wd_fire |=> wd_cause_r && st_r == ST_POWER_UP)
		else $error("watchdog fire without cause");
	wd_asleep_a: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r == ST_ASLEEP) |-> wd_pre_r == 18'h0)
		else $error("watchdog counted while asleep");
	wd_frozen_a: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r != ST_AWAKE) |=> wd_pre_r == 18'h0)
		else $error("watchdog prescaler ran outside awake");
endmodule

// >>> core/sync2.sv
// two-flop synchroniser for a bundle of asynchronous levels
// assumes the inputs are quasi-static against clk
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// meta_r feeds only q
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// >>> verif/far_side_model.sv
// far side of the supervisor: usb block requests and the slow oscillator
// assumes clk is the supervisor clock and the bench commands usb sleep and resume
`timescale 1ns/1ps
module far_side_model (
	input  wire logic clk,
	input  wire logic awake,
	input  wire logic sleep_cmd,
	input  wire logic resume_cmd,
	output logic      usb_standby_req,
	output logic      usb_resume,
	output logic      slow_osc
);
	logic [3:0] div_r = 4'h0;

	always_ff @(posedge clk)
	begin
		div_r <= div_r + 4'h1;
	end

	// slow enough that the two-flop sync never drops an edge
	assign slow_osc        = div_r[3];
	// usb may only ask for standby while the chip runs
	assign usb_standby_req = sleep_cmd & awake;
	assign usb_resume      = resume_cmd;
endmodule

// >>> verif/sleep_wake_supervisor_tb.sv
// self-checking bench for the sleep/wake supervisor
// assumes the far-side model drives usb and slow clock; supplies and pin come from here
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module sleep_wake_supervisor_tb;
	import sleep_wake_pkg::*;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
	logic        clk, rst_b, wr, rd, wake_pin, sleep_cmd, resume_cmd;
	logic        usb_standby_req, usb_resume, slow_osc, chip_reset_b, awake, irq;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, x, y;
	logic [2:0]  supply_good;
	logic [5:0]  sleep_ctrl;
	int          num_errors = 0;
	int          n_tests = 0;
	row_t        rows[10];

	far_side_model fs (.clk(clk), .awake(awake), .sleep_cmd(sleep_cmd), .resume_cmd(resume_cmd),
		.usb_standby_req(usb_standby_req), .usb_resume(usb_resume), .slow_osc(slow_osc));

	sleep_wake_supervisor dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .usb_standby_req(usb_standby_req), .usb_resume(usb_resume), .wake_pin(wake_pin),
		.slow_osc(slow_osc), .supply_good(supply_good), .chip_reset_b(chip_reset_b), .awake(awake),
		.sleep_ctrl(sleep_ctrl), .irq(irq));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic test_done();
		$display("counts: %0d compares, %0d mismatches", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic ended(input string s);
		$display("test %s done", s);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// sel 0 watches awake, sel 1 watches chip_reset_b
	// starts off the edge so an output launched at this edge is settled
	task automatic wait_for(input int sel, input logic v, input int n);
		int i;
		#1;
		for (i = 0; i < n && (sel ? chip_reset_b : awake) !== v; i++)
		begin
			@(posedge clk);
			#1;
		end
		if ((sel ? chip_reset_b : awake) !== v)
		begin
			`CHK(sel ? chip_reset_b : awake, v)
			test_done();
		end
	endtask

	initial
	begin
		rows = '{'{1'b0, OFS_INCR, 32'h0, INCR_RST}, '{1'b0, OFS_ALARM_LO, 32'h0, 32'hffff_ffff},
			'{1'b0, OFS_STATUS, 32'h0, 32'h1}, '{1'b0, 8'h40, 32'h0, 32'h0},
			'{1'b0, OFS_WDOG, 32'h0, {16'h0, WDOG_RST}}, '{1'b1, OFS_RETAIN, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
			'{1'b1, 8'hfc, 32'h1234_5678, 32'h1234_5678}, '{1'b1, OFS_INCR, 32'h10, 32'h10},
			'{1'b1, OFS_IRQ_MASK, 32'h2, 32'h2}, '{1'b1, OFS_SLEEP_CFG, 32'h2a, 32'h2a}};
		{wr, rd, wake_pin, sleep_cmd, resume_cmd} = 5'h0;
		addr = 8'h0;
		wdata = 32'h0;
		supply_good = 3'h0;
		rst_b = 1'b0;
		repeat (16) @(posedge clk);
		`CHK(chip_reset_b, 1'b0)
		`CHK(awake, 1'b0)
		rst_b <= 1'b1;
		repeat (8) @(posedge clk);
		#1;
		`CHK(chip_reset_b, 1'b0)
		@(posedge clk);
		supply_good <= 3'h7;
		wait_for(1, 1'b1, 20);
		wait_for(0, 1'b1, 20);
		ended("reset");

		foreach (rows[i])
		begin
			if (rows[i].w)
				wr_reg(rows[i].a, rows[i].d);
			rd_reg(rows[i].a, x);
			`CHK(x, rows[i].e)
		end
		`CHK(sleep_ctrl, 6'h2a)
		rd_reg(OFS_RTC_LO, x);
		repeat (10) @(posedge clk);
		rd_reg(OFS_RTC_LO, y);
		`CHK(y - x, 32'd12)
		ended("registers");

		// pin edge arrives mid-transition and must wake at arrival
		wr_reg(OFS_WAKE_CFG, 32'h3);
		wr_reg(OFS_CTRL, 32'h1);
		wait_for(0, 1'b0, 4);
		@(posedge clk);
		wake_pin <= 1'b1;
		wait_for(0, 1'b1, 40);
		`CHK(irq, 1'b1)
		rd_reg(OFS_IRQ_STAT, x);
		`CHK(x, 32'h3)
		repeat (2) @(posedge clk);
		#1;
		`CHK(irq, 1'b0)
		rd_reg(OFS_RETAIN, x);
		`CHK(x, 32'ha5a5_5a5a)
		@(posedge clk);
		wake_pin <= 1'b0;
		repeat (6) @(posedge clk);
		wake_pin <= 1'b1;
		repeat (20) @(posedge clk);
		rd_reg(OFS_STATUS, x);
		`CHK(x, 32'h1)
		ended("held wake");

		wr_reg(OFS_WAKE_CFG, 32'h18);
		@(posedge clk);
		sleep_cmd <= 1'b1;
		wait_for(0, 1'b0, 6);
		@(posedge clk);
		sleep_cmd <= 1'b0;
		repeat (12) @(posedge clk);
		rd_reg(OFS_STATUS, x);
		`CHK(x, 32'h4)
		rd_reg(OFS_RTC_LO, x);
		repeat (64) @(posedge clk);
		rd_reg(OFS_RTC_LO, y);
		`CHK((y - x) & 32'hf, 32'h0)
		`CHK((y - x) != 32'h0, 1'b1)
		@(posedge clk);
		resume_cmd <= 1'b1;
		wait_for(0, 1'b1, 40);
		@(posedge clk);
		resume_cmd <= 1'b0;
		ended("usb sleep");

		wr_reg(OFS_WAKE_CFG, 32'h4);
		rd_reg(OFS_RTC_HI, y);
		rd_reg(OFS_RTC_LO, x);
		wr_reg(OFS_ALARM_HI, y);
		wr_reg(OFS_ALARM_LO, x + 32'd300);
		wr_reg(OFS_CTRL, 32'h1);
		wait_for(0, 1'b0, 6);
		repeat (100) @(posedge clk);
		#1;
		`CHK(awake, 1'b0)
		wait_for(0, 1'b1, 300);
		ended("alarm");

		// falling pin edge while fully asleep wakes directly
		wr_reg(OFS_WAKE_CFG, 32'h1);
		wr_reg(OFS_CTRL, 32'h1);
		wait_for(0, 1'b0, 6);
		repeat (10) @(posedge clk);
		rd_reg(OFS_STATUS, x);
		`CHK(x, 32'h4)
		@(posedge clk);
		wake_pin <= 1'b0;
		wait_for(0, 1'b1, 40);
		ended("pin wake");

		// a supply dropping mid-transition must force a cold start
		wr_reg(OFS_CTRL, 32'h1);
		wait_for(0, 1'b0, 6);
		@(posedge clk);
		supply_good <= 3'h5;
		wait_for(1, 1'b0, 10);
		@(posedge clk);
		supply_good <= 3'h7;
		wait_for(1, 1'b1, 20);
		wait_for(0, 1'b1, 20);
		rd_reg(OFS_STATUS, x);
		`CHK(x, 32'h1)
		ended("supply loss");
		test_done();
	end
endmodule
